// >>> rtl/pmp_cpu_end.sv
// cpu core end: fetch sequencing, data writes, shadow page copy
//
// Design decision made here: the address-and-strobe port.
module pmp_cpu_end (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // link to the page mapper
   pmp_if.cpu link,
   // user fetch requests
   input wire logic usrFetchReq,
   input wire logic [pmp_pkg::PC_W-1:0] usrFetchPc,
   output logic [pmp_pkg::DATA_W-1:0] usrFetchData,
   output logic usrFetchValid,
   // user data space access
   input wire logic usrWr,
   input wire logic usrRd,
   input wire logic [pmp_pkg::DADDR_W-1:0] usrAddr,
   input wire logic [pmp_pkg::DATA_W-1:0] usrWrData,
   output logic [pmp_pkg::DATA_W-1:0] usrRdData,
   output logic usrBusy,
   // calls, returns and interrupts
   input wire logic usrCall,
   input wire logic usrRet,
   input wire logic usrIrq,
   input wire logic [1:0] usrIrqIdx,
   input wire logic [pmp_pkg::PC_W-1:0] usrRetPc,
   output logic [pmp_pkg::PC_W-1:0] usrPopPc,
   output logic usrPopValid,
   // status
   output logic [pmp_pkg::PC_W-1:0] vecPc,
   output logic vecFetch,
   output logic reservedHit,
   output logic pageSeqErr
);
   import pmp_pkg::*;

   pmp_cpu_state_t state_ff;
   logic [DATA_W-1:0] shadow_ff;
   logic [DATA_W-1:0] pendData_ff;
   logic fetchReq_ff;
   logic [PC_W-1:0] fetchPc_ff;
   logic dataWr_ff;
   logic dataRd_ff;
   logic [DADDR_W-1:0] dataAddr_ff;
   logic [DATA_W-1:0] dataWrData_ff;
   logic push_ff;
   logic pop_ff;
   logic [PC_W-1:0] pushPc_ff;
   logic shadowRd_ff;
   logic vecFetch_ff;
   logic reservedHit_ff;
   logic pageSeqErr_ff;
   logic pageWrReq;

   assign pageWrReq = usrWr && usrAddr == PAGE_SEL_ADDR;

   // ***************************************************************
   // sequencing: boot vector, running, page write
   // ***************************************************************

   // the page write takes two cycles so the shadow is always first
   always_ff @(posedge core_clk) begin
      if (!reset_n || link.restart) begin
         state_ff <= PMP_BOOT;
      end else begin
         case (state_ff)
            PMP_BOOT: state_ff <= PMP_RUN;
            PMP_RUN: state_ff <= pageWrReq ? PMP_PAGEWR : PMP_RUN;
            PMP_PAGEWR: state_ff <= PMP_RUN;
            default: state_ff <= PMP_BOOT;
         endcase
      end
   end

   assign usrBusy = state_ff != PMP_RUN;

   // shadow copy in ram, updated ahead of the page select itself
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         shadow_ff <= '0;
         pendData_ff <= '0;
      end else if (state_ff == PMP_RUN && usrWr && (pageWrReq || usrAddr == SHADOW_ADDR)) begin
         shadow_ff <= usrWrData;
         pendData_ff <= usrWrData;
      end
   end

   // ***************************************************************
   // fetch path, vectors take priority over user fetches
   // ***************************************************************
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         fetchReq_ff <= 1'b0;
         fetchPc_ff <= '0;
         vecFetch_ff <= 1'b0;
      end else if (state_ff == PMP_BOOT) begin
         fetchReq_ff <= !link.restart;
         fetchPc_ff <= RESET_VEC;
         vecFetch_ff <= !link.restart;
      end else if (link.nmiEvt) begin
         fetchReq_ff <= 1'b1;
         fetchPc_ff <= NMI_VEC;
         vecFetch_ff <= 1'b1;
      end else if (usrIrq) begin
         fetchReq_ff <= 1'b1;
         fetchPc_ff <= IRQ_VEC_BASE | PC_W'({usrIrqIdx, 1'b0});
         vecFetch_ff <= 1'b1;
      end else begin
         fetchReq_ff <= usrFetchReq;
         fetchPc_ff <= usrFetchPc;
         vecFetch_ff <= 1'b0;
      end
   end

   // reserved area watch on the page held in the shadow copy
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         reservedHit_ff <= 1'b0;
      end else begin
         reservedHit_ff <= usrFetchReq && pmp_reserved(usrFetchPc, shadow_ff[PAGE_W-1:0]);
      end
   end

   // rewriting the page select from a dynamic page breaks the hop order
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pageSeqErr_ff <= 1'b0;
      end else begin
         pageSeqErr_ff <= state_ff == PMP_RUN && pageWrReq && !fetchPc_ff[PC_W-1];
      end
   end

   // ***************************************************************
   // data space and stack requests
   // ***************************************************************
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         dataWr_ff <= 1'b0;
         dataRd_ff <= 1'b0;
         dataAddr_ff <= '0;
         dataWrData_ff <= '0;
         shadowRd_ff <= 1'b0;
      end else if (state_ff == PMP_PAGEWR) begin
         dataWr_ff <= 1'b1;
         dataRd_ff <= 1'b0;
         dataAddr_ff <= PAGE_SEL_ADDR;
         dataWrData_ff <= pendData_ff;
         shadowRd_ff <= 1'b0;
      end else begin
         dataWr_ff <= usrWr && !pageWrReq && state_ff == PMP_RUN;
         dataRd_ff <= usrRd && usrAddr != SHADOW_ADDR;
         dataAddr_ff <= usrAddr;
         dataWrData_ff <= usrWrData;
         shadowRd_ff <= usrRd && usrAddr == SHADOW_ADDR;
      end
   end

   // interrupt entry pushes like a call; the page is never stacked
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         push_ff <= 1'b0;
         pop_ff <= 1'b0;
         pushPc_ff <= '0;
      end else begin
         push_ff <= usrCall || usrIrq || link.nmiEvt;
         pop_ff <= usrRet && !usrCall;
         pushPc_ff <= usrRetPc;
      end
   end

   assign link.fetchReq = fetchReq_ff;
   assign link.fetchPc = fetchPc_ff;
   assign link.dataWr = dataWr_ff;
   assign link.dataRd = dataRd_ff;
   assign link.dataAddr = dataAddr_ff;
   assign link.dataWrData = dataWrData_ff;
   assign link.push = push_ff;
   assign link.pop = pop_ff;
   assign link.pushPc = pushPc_ff;
   assign usrFetchData = link.fetchData;
   assign usrFetchValid = link.fetchValid;
   assign usrPopPc = link.popPc;
   assign usrPopValid = link.popValid;
   assign vecPc = fetchPc_ff;
   assign vecFetch = vecFetch_ff;
   assign reservedHit = reservedHit_ff;
   assign pageSeqErr = pageSeqErr_ff;
   // shadow read returns the ram copy, others the device answer
   assign usrRdData = shadowRd_ff ? shadow_ff : link.dataRdData;

endmodule

// >>> rtl/pmp_if.sv
// link between the cpu core end and the page mapper end
interface pmp_if;
   import pmp_pkg::*;

   logic fetchReq;
   logic [PC_W-1:0] fetchPc;
   logic [DATA_W-1:0] fetchData;
   logic fetchValid;
   logic dataWr;
   logic dataRd;
   logic [DADDR_W-1:0] dataAddr;
   logic [DATA_W-1:0] dataWrData;
   logic [DATA_W-1:0] dataRdData;
   logic push;
   logic pop;
   logic [PC_W-1:0] pushPc;
   logic [PC_W-1:0] popPc;
   logic popValid;
   logic nmiEvt;
   logic restart;

   modport dev (
      input fetchReq, fetchPc, dataWr, dataRd, dataAddr, dataWrData, push, pop, pushPc,
      output fetchData, fetchValid, dataRdData, popPc, popValid, nmiEvt, restart
   );
   modport cpu (
      output fetchReq, fetchPc, dataWr, dataRd, dataAddr, dataWrData, push, pop, pushPc,
      input fetchData, fetchValid, dataRdData, popPc, popValid, nmiEvt, restart
   );
endinterface

// >>> rtl/pmp_mapper.sv
// page mapper end: page select, program memory, return stack, pins
module pmp_mapper #(
   parameter int MEM_BYTES = 8192,
   parameter bit NMI_PULLUP = 1'b1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // link to the cpu core end
   pmp_if.dev link,
   // device pins
   input wire logic resetPinN,
   input wire logic testHigh,
   input wire logic nmiPin,
   output logic nmiPullUpEn,
   // programming port, only honoured in programming mode
   input wire logic progWr,
   input wire logic [pmp_pkg::PHYS_W-1:0] progAddr,
   input wire logic [pmp_pkg::DATA_W-1:0] progData,
   // status
   output logic progMode,
   output logic [pmp_pkg::PAGE_W-1:0] activePage,
   output logic stackFull
);
   import pmp_pkg::*;

   initial begin
      if (MEM_BYTES != (1 << PHYS_W)) begin
         $error("program memory must be four pages of 2K bytes");
      end
   end

   // ***************************************************************
   // state
   // ***************************************************************
   logic [DATA_W-1:0] progMem [MEM_BYTES];
   logic [PAGE_W-1:0] pageSel_ff;
   logic [DATA_W-1:0] fetchData_ff;
   logic fetchValid_ff;
   logic [DATA_W-1:0] rdData_ff;
   logic restart_ff;
   logic progMode_ff;
   logic nmiSync1_ff;
   logic nmiSync2_ff;
   logic nmiPrev_ff;
   logic nmiEvt_ff;
   logic [PHYS_W-1:0] fetchPhys;

   // ***************************************************************
   // page select register
   // ***************************************************************

   // the register only reacts to a data write at its own address;
   // calls, returns and interrupt entries have no path into it
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pageSel_ff <= PAGE_SEL_RST;
      end else if (link.dataWr && link.dataAddr == PAGE_SEL_ADDR) begin
         pageSel_ff <= link.dataWrData[PAGE_W-1:0];
      end
   end

   // reads of the page select give a fixed value, so nothing leaks out
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rdData_ff <= '0;
      end else if (link.dataRd) begin
         rdData_ff <= WO_READ_VAL;
      end else begin
         rdData_ff <= '0;
      end
   end

   assign link.dataRdData = rdData_ff;
   assign activePage = pageSel_ff;

   // ***************************************************************
   // instruction fetch through the page mapping
   // ***************************************************************

   // the twelve-bit counter reaches 4K logically, 8K physically
   assign fetchPhys = pmp_phys(link.fetchPc, pageSel_ff);

   // one array serves both the low and the high view of the static page,
   // so a write through either is seen through the other
   always_ff @(posedge core_clk) begin
      if (progMode_ff && progWr) begin
         progMem[progAddr] <= progData;
      end
   end

   // fetch data stands one cycle after the request
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         fetchData_ff <= '0;
         fetchValid_ff <= 1'b0;
      end else begin
         fetchValid_ff <= link.fetchReq && !progMode_ff;
         if (link.fetchReq) begin
            fetchData_ff <= progMem[fetchPhys];
         end
      end
   end

   assign link.fetchData = fetchData_ff;
   assign link.fetchValid = fetchValid_ff;

   // ***************************************************************
   // return stack
   // ***************************************************************

   // stack holds program counters only; the page field is not saved
   pmp_ret_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(PC_W)
   ) retStack (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .push(link.push),
      .pop(link.pop),
      .pushData(link.pushPc),
      .popData(link.popPc),
      .popValid(link.popValid),
      .full(stackFull),
      .empty()
   );

   // ***************************************************************
   // reset pin and test pin
   // ***************************************************************

   // a low reset pin holds the core in restart; the cpu end then
   // re-enters through the reset vector
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         restart_ff <= 1'b1;
      end else begin
         restart_ff <= !resetPinN;
      end
   end

   assign link.restart = restart_ff;

   // the test level is sampled only while reset is in force, so a change
   // during normal running cannot drop the part into programming mode
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         progMode_ff <= 1'b0;
      end else if (restart_ff) begin
         progMode_ff <= testHigh;
      end
   end

   assign progMode = progMode_ff;

   // ***************************************************************
   // non-maskable interrupt pin
   // ***************************************************************

   // the pin is asynchronous, so it passes two flops before edge sensing
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         nmiSync1_ff <= 1'b1;
         nmiSync2_ff <= 1'b1;
         nmiPrev_ff <= 1'b1;
      end else begin
         nmiSync1_ff <= nmiPin;
         nmiSync2_ff <= nmiSync1_ff;
         nmiPrev_ff <= nmiSync2_ff;
      end
   end

   // falling edge gives a one-cycle event, suppressed while restarting
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         nmiEvt_ff <= 1'b0;
      end else begin
         nmiEvt_ff <= nmiPrev_ff && !nmiSync2_ff && !restart_ff && !progMode_ff;
      end
   end

   assign link.nmiEvt = nmiEvt_ff;
   assign nmiPullUpEn = NMI_PULLUP;

endmodule

// >>> rtl/pmp_pkg.sv
// constants, types and shared helpers of the program space page mapper
//
// Functional notes
// - program counter is twelve bits wide
// - four 2K pages; low range follows page select
// - counter top bit forces the static page
// - static page reachable low too, same storage
// - page select at data CAh, write-only
// - software writes page select as whole bytes
// - calls, returns, interrupts leave page select alone
// - dynamic to dynamic hops pass through static page
// - interrupt code changes page only with shadow
// - shadow copy written before page select
// - vectors: irq FF0-FF7, nmi FFC, reset FFE
// - code avoids reserved areas in each page
// - nmi taken on falling edge, pull-up optional
// - test high during reset enters programming mode
// - low reset pin restarts through reset vector
// - six-entry return stack for calls and interrupts
// - two-bit field picks pages 0 to 3
// - page select undefined after reset; the mapper resets it to page 0 (PAGE_SEL_RST)
package pmp_pkg;

   // ***************************************************************
   // widths and stack depth
   // ***************************************************************
   localparam int PC_W = 12;
   localparam int PAGE_W = 2;
   localparam int OFS_W = 11;
   localparam int PHYS_W = 13;
   localparam int DATA_W = 8;
   localparam int DADDR_W = 8;
   localparam int STACK_DEPTH = 6;

   // ***************************************************************
   // data space locations, reset and read values, static page
   // ***************************************************************
   localparam logic [DADDR_W-1:0] PAGE_SEL_ADDR = 8'hca;
   localparam logic [DADDR_W-1:0] SHADOW_ADDR = 8'hbf;
   localparam logic [PAGE_W-1:0] PAGE_SEL_RST = 2'h0;
   localparam logic [DATA_W-1:0] WO_READ_VAL = 8'h00;
   localparam logic [PAGE_W-1:0] STATIC_PAGE = 2'h1;

   // ***************************************************************
   // vectors and reserved areas of program space
   // ***************************************************************
   localparam logic [PC_W-1:0] IRQ_VEC_BASE = 12'hff0;
   localparam logic [PC_W-1:0] NMI_VEC = 12'hffc;
   localparam logic [PC_W-1:0] RESET_VEC = 12'hffe;
   localparam logic [PC_W-1:0] RSV_P0_END = 12'h07f;
   localparam logic [PC_W-1:0] RSV_P23_END = 12'h00f;
   localparam logic [PC_W-1:0] RSV_ST_LO = 12'hfa0;
   localparam logic [PC_W-1:0] RSV_ST_HI = 12'hfef;
   localparam logic [PC_W-1:0] RSV_VG_LO = 12'hff8;
   localparam logic [PC_W-1:0] RSV_VG_HI = 12'hffb;

   // cpu end fetch sequencing
   typedef enum logic [1:0] {
      PMP_BOOT = 2'b00,
      PMP_RUN = 2'b01,
      PMP_PAGEWR = 2'b11
   } pmp_cpu_state_t;

   // physical program address from counter and page field
   function automatic logic [PHYS_W-1:0] pmp_phys(input logic [PC_W-1:0] pc,
                                                  input logic [PAGE_W-1:0] page);
      logic [PAGE_W-1:0] pg;
      pg = pc[PC_W-1] ? STATIC_PAGE : page;
      return {pg, pc[OFS_W-1:0]};
   endfunction

   // true when a logical fetch address hits a reserved area
   function automatic logic pmp_reserved(input logic [PC_W-1:0] pc,
                                         input logic [PAGE_W-1:0] page);
      logic hit;
      hit = 1'b0;
      if (pc[PC_W-1] || page == STATIC_PAGE) begin
         hit = (pc[OFS_W-1:0] >= RSV_ST_LO[OFS_W-1:0] && pc[OFS_W-1:0] <= RSV_ST_HI[OFS_W-1:0])
            || (pc[OFS_W-1:0] >= RSV_VG_LO[OFS_W-1:0] && pc[OFS_W-1:0] <= RSV_VG_HI[OFS_W-1:0]);
      end else if (page == 2'h0) begin
         hit = pc <= RSV_P0_END;
      end else begin
         hit = pc <= RSV_P23_END;
      end
      return hit;
   endfunction

endpackage

// >>> rtl/pmp_pkg_unused_guard.sv
// holds no definitions

// >>> rtl/pmp_ret_stack.sv
// hardware return address stack
module pmp_ret_stack #(
   parameter int DEPTH = pmp_pkg::STACK_DEPTH,
   parameter int WIDTH = pmp_pkg::PC_W
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // stack operations
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] pushData,
   output logic [WIDTH-1:0] popData,
   output logic popValid,
   output logic full,
   output logic empty
);
   import pmp_pkg::*;

   localparam int CNT_W = $clog2(DEPTH + 1);

   initial begin
      if (DEPTH < 1 || WIDTH < 1) begin
         $error("return stack needs depth and width of at least one");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [CNT_W-1:0] level_ff;
   logic [WIDTH-1:0] popData_ff;
   logic popValid_ff;

   assign full = level_ff == CNT_W'(DEPTH);
   assign empty = level_ff == '0;
   assign popData = popData_ff;
   assign popValid = popValid_ff;

   // a push onto a full stack drops the oldest entry, like a shift register
   always_ff @(posedge core_clk) begin
      if (push && !pop) begin
         mem[0] <= pushData;
         for (int i = 1; i < DEPTH; i++) begin
            mem[i] <= mem[i-1];
         end
      end else if (pop && !push && !empty) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            mem[i] <= mem[i+1];
         end
      end
   end

   // fill level
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         level_ff <= '0;
      end else if (push && !pop && !full) begin
         level_ff <= level_ff + 1'b1;
      end else if (pop && !push && !empty) begin
         level_ff <= level_ff - 1'b1;
      end
   end

   // popped address stands for one cycle after the pop
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         popData_ff <= '0;
         popValid_ff <= 1'b0;
      end else begin
         popValid_ff <= pop && !push && !empty;
         if (pop && !push && !empty) begin
            popData_ff <= mem[0];
         end
      end
   end
endmodule

// >>> tb/pmp_link_chk.sv
// assertions on the link between the cpu end and the page mapper end
module pmp_link_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // fetch path
   input wire logic fetchReq,
   input wire logic [pmp_pkg::PC_W-1:0] fetchPc,
   input wire logic fetchValid,
   // data space path
   input wire logic dataWr,
   input wire logic dataRd,
   input wire logic [pmp_pkg::DATA_W-1:0] dataRdData,
   // stack and events
   input wire logic push,
   input wire logic pop,
   input wire logic popValid,
   input wire logic nmiEvt,
   input wire logic restart
);
   import pmp_pkg::*;

   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   // every fetch is answered exactly one cycle later
   property p_fetch_ans;
      fetchReq |=> fetchValid;
   endproperty
   a_fetch_ans: assert property (p_fetch_ans) else $error("fetch not answered");

   // no answer without a request the cycle before
   property p_no_stray;
      fetchValid |-> $past(fetchReq);
   endproperty
   a_no_stray: assert property (p_no_stray) else $error("stray fetch answer");

   // leaving restart starts at the reset vector
   property p_boot;
      $fell(restart) |=> fetchReq && fetchPc == RESET_VEC;
   endproperty
   a_boot: assert property (p_boot) else $error("no reset vector fetch");

   // a held restart keeps the core from fetching
   property p_hold;
      restart && $past(restart) |-> !fetchReq;
   endproperty
   a_hold: assert property (p_hold) else $error("fetch during restart");

   // page select is write-only, reads give the fixed value
   property p_rd_zero;
      dataRd |=> dataRdData == WO_READ_VAL;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("read data not fixed");

   property p_pop;
      pop |=> popValid;
   endproperty
   a_pop: assert property (p_pop) else $error("pop not answered");

   // one event per falling edge
   property p_nmi_pulse;
      nmiEvt |=> !nmiEvt;
   endproperty
   a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi event too long");

   property p_nmi_vec;
      nmiEvt |=> fetchReq && fetchPc == NMI_VEC && push;
   endproperty
   a_nmi_vec: assert property (p_nmi_vec) else $error("nmi vector not taken");

   // stack traffic never writes data space, so page select is left alone
   property p_keep;
      (push || pop) |-> !dataWr;
   endproperty
   a_keep: assert property (p_keep) else $error("write beside stack traffic");

   // main scenarios
   c_fetch: cover property (fetchReq ##1 fetchValid);
   c_nmi: cover property (nmiEvt);
   c_wr: cover property (dataWr);
endmodule

// >>> tb/tb.sv
// self-checking bench joining the cpu end and the page mapper end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pmp_pkg::*;

   // ***************************************************************
   // signals and instances
   // ***************************************************************
   logic core_clk = 1'h0, reset_n = 1'h0;
   logic resetPinN = 1'h0, testHigh = 1'h0, nmiPin = 1'h1, progWr = 1'h0;
   logic [PHYS_W-1:0] progAddr = 13'h0;
   logic [DATA_W-1:0] progData = 8'h0, usrWrData = 8'h0, usrFetchData, usrRdData;
   logic [PC_W-1:0] usrFetchPc = 12'h0, usrRetPc = 12'h0, usrPopPc, vecPc;
   logic [DADDR_W-1:0] usrAddr = 8'h0;
   logic [1:0] usrIrqIdx = 2'h0;
   logic [PAGE_W-1:0] activePage;
   logic usrFetchReq = 1'h0, usrWr = 1'h0, usrRd = 1'h0;
   logic usrCall = 1'h0, usrRet = 1'h0, usrIrq = 1'h0;
   logic nmiPullUpEn, progMode, stackFull, usrFetchValid, usrBusy, usrPopValid;
   logic vecFetch, reservedHit, pageSeqErr;
   int fails = 0, check_count = 0, cyc = 0;

   pmp_if link();
   pmp_mapper pmp_mapper_inst (.core_clk, .reset_n, .link(link), .resetPinN, .testHigh,
      .nmiPin, .nmiPullUpEn, .progWr, .progAddr, .progData, .progMode, .activePage,
      .stackFull);
   pmp_cpu_end pmp_cpu_end_inst (.core_clk, .reset_n, .link(link), .usrFetchReq,
      .usrFetchPc, .usrFetchData, .usrFetchValid, .usrWr, .usrRd, .usrAddr, .usrWrData,
      .usrRdData, .usrBusy, .usrCall, .usrRet, .usrIrq, .usrIrqIdx, .usrRetPc, .usrPopPc,
      .usrPopValid, .vecPc, .vecFetch, .reservedHit, .pageSeqErr);
   pmp_link_chk pmp_link_chk_inst (.core_clk, .reset_n, .fetchReq(link.fetchReq),
      .fetchPc(link.fetchPc), .fetchValid(link.fetchValid), .dataWr(link.dataWr),
      .dataRd(link.dataRd), .dataRdData(link.dataRdData), .push(link.push),
      .pop(link.pop), .popValid(link.popValid), .nmiEvt(link.nmiEvt),
      .restart(link.restart));

   // 125 MHz core clock
   always #4 core_clk = ~core_clk;

   // ***************************************************************
   // tasks
   // ***************************************************************
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // bounded wait, looked at just after each edge
   task automatic waitf(ref logic f, input logic lvl);
      int i;
      i = 0;
      #1;
      while (f !== lvl && i < 20) begin
         @(posedge core_clk);
         #1;
         i++;
      end
   endtask

   task automatic fetch(input logic [PC_W-1:0] pc, input logic [DATA_W-1:0] e);
      @(posedge core_clk);
      usrFetchReq <= 1'h1;
      usrFetchPc <= pc;
      @(posedge core_clk);
      usrFetchReq <= 1'h0;
      #1;
      chk("rsvHit", 1'h0, reservedHit);
      waitf(usrFetchValid, 1'h1);
      chk("fetchData", e, usrFetchData);
   endtask

   // page writes keep the core busy for one cycle
   task automatic wr(input logic [DADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      usrWr <= 1'h1;
      usrAddr <= a;
      usrWrData <= d;
      @(posedge core_clk);
      usrWr <= 1'h0;
      #1;
      chk("seqErr", !usrFetchPc[PC_W-1] && a == PAGE_SEL_ADDR, pageSeqErr);
      repeat (3) @(posedge core_clk);
      waitf(usrBusy, 1'h0);
   endtask

   // shadow location answers one cycle sooner than the mapper
   task automatic rd(input logic [DADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge core_clk);
      usrRd <= 1'h1;
      usrAddr <= a;
      @(posedge core_clk);
      usrRd <= 1'h0;
      if (a != SHADOW_ADDR) @(posedge core_clk);
      #1;
      chk("rdData", e, usrRdData);
   endtask

   // k: 0 call, 1 return, 2 interrupt
   task automatic op(input int k, input logic [PC_W-1:0] pc, input logic [1:0] ix);
      @(posedge core_clk);
      usrCall <= (k == 0);
      usrRet <= (k == 1);
      usrIrq <= (k == 2);
      usrRetPc <= pc;
      usrIrqIdx <= ix;
      @(posedge core_clk);
      {usrCall, usrRet, usrIrq} <= 3'h0;
   endtask

   task automatic boot();
      @(posedge core_clk);
      resetPinN <= 1'h1;
      waitf(vecFetch, 1'h1);
      chk("bootVec", RESET_VEC, vecPc);
      waitf(usrBusy, 1'h0);
   endtask

   // ***************************************************************
   // tests
   // ***************************************************************
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 4000) begin
         fails++;
         end_sim();
      end
   end

   initial begin
      repeat (4) @(posedge core_clk);
      reset_n <= 1'h1;
      testHigh <= 1'h1;
      repeat (3) @(posedge core_clk);
      #1;
      chk("progMode", 1'h1, progMode);
      chk("pullUp", 1'h1, nmiPullUpEn);
      for (int p = 0; p < 4; p++) begin
         @(posedge core_clk);
         progWr <= 1'h1;
         progAddr <= {p[1:0], 11'h100};
         progData <= 8'h10 + 8'(p);
      end
      @(posedge core_clk);
      progWr <= 1'h0;
      testHigh <= 1'h0;
      repeat (3) @(posedge core_clk);
      #1;
      chk("progMode", 1'h0, progMode);
      boot();
      $display("test boot done");
      // hop through the static page before each page change
      for (int p = 0; p < 4; p++) begin
         fetch(12'h900, 8'h11);
         wr(PAGE_SEL_ADDR, 8'(p));
         chk("activePage", p[1:0], activePage);
         rd(SHADOW_ADDR, 8'(p));
         fetch(12'h100, 8'h10 + 8'(p));
      end
      rd(PAGE_SEL_ADDR, WO_READ_VAL);
      wr(PAGE_SEL_ADDR, 8'h3);
      $display("test paging done");
      // one push past the depth drops the oldest entry
      for (int i = 0; i < 7; i++) op(0, 12'h100 + 12'(i), 2'h0);
      repeat (2) @(posedge core_clk);
      #1;
      chk("stackFull", 1'h1, stackFull);
      for (int i = 6; i > 0; i--) begin
         op(1, 12'h0, 2'h0);
         waitf(usrPopValid, 1'h1);
         chk("popPc", 12'h100 + 12'(i), usrPopPc);
      end
      chk("pageKept", 2'h3, activePage);
      $display("test stack done");
      for (int i = 0; i < 4; i++) begin
         op(2, 12'h0, 2'(i));
         waitf(vecFetch, 1'h1);
         chk("irqVec", IRQ_VEC_BASE + 12'(2 * i), vecPc);
         op(1, 12'h0, 2'h0);
         waitf(usrPopValid, 1'h1);
      end
      chk("pageKept", 2'h3, activePage);
      @(posedge core_clk);
      nmiPin <= 1'h0;
      waitf(vecFetch, 1'h1);
      chk("nmiVec", NMI_VEC, vecPc);
      @(posedge core_clk);
      nmiPin <= 1'h1;
      op(1, 12'h0, 2'h0);
      waitf(usrPopValid, 1'h1);
      $display("test vectors done");
      // restart from the pin in mid-run
      @(posedge core_clk);
      resetPinN <= 1'h0;
      repeat (4) @(posedge core_clk);
      boot();
      fetch(12'h900, 8'h11);
      $display("test restart done");
      end_sim();
   end
endmodule
